//--- rtl/ca_pkg.sv
// Purpose: shared constants and types for the command/address link
// Assumes: both ends run on one 250 MHz sys_clk
// Notes: bit k of a cmd_addr_bit vector is link bit k (bit 0 first)
`default_nettype none
package ca_pkg;
  localparam int CA_W = 10;
  localparam int ROW_W = 15;
  localparam int COL_W = 12;
  localparam int BANK_W = 3;
  localparam int MR_W = 8;
  localparam int NUM_BANKS = 8;
  localparam int PER_BANK_REFRESH_BANKS = 8;
  // rising-half opcodes on link bits 3..0
  localparam logic [3:0] OP_MRW = 4'h0;
  localparam logic [3:0] OP_MRR = 4'h8;
  localparam logic [3:0] OP_REF_BANK = 4'h4;
  localparam logic [3:0] OP_REF_ALL = 4'hc;
  localparam logic [3:0] OP_PRECHARGE = 4'hb;
  localparam logic [3:0] OP_BST = 4'h3;
  localparam logic [1:0] OP_ACT = 2'h2;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h5;
  localparam logic [2:0] OP_SELF_REFRESH_STATE = 3'h4;
  localparam logic [2:0] OP_DPD = 3'h3;
  // field positions within the two halves
  localparam int RISE_MR_POS = 4;
  localparam int RISE_ROW_POS = 2;
  localparam int RISE_AB_POS = 4;
  localparam int RISE_COL_POS = 5;
  localparam int RISE_BANK_POS = 7;
  localparam int FALL_AP_POS = 0;
  localparam int FALL_COL_POS = 1;
  localparam int FALL_OP_POS = 2;
  // controller register map, byte offsets
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_MODE = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int CMD_CODE_POS = 0;
  localparam int CMD_AP_POS = 4;
  localparam int CMD_AB_POS = 5;
  localparam int CMD_BANK_POS = 8;
  localparam int ADDR_ROW_POS = 0;
  localparam int ADDR_COL_POS = 16;
  localparam int MODE_IDX_POS = 0;
  localparam int MODE_OP_POS = 8;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_PWR_POS = 1;
  localparam int STAT_ERR_POS = 3;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int POWERDOWN_EXIT_NS = 20;
  localparam int SELFREFRESH_EXIT_NS = 200;
  localparam logic [15:0] POWERDOWN_EXIT_CYCLES = 16'((POWERDOWN_EXIT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] SELFREFRESH_EXIT_CYCLES =
    16'((SELFREFRESH_EXIT_NS * CLK_MHZ + 999) / 1000);
  localparam int AP_CNT_W = 4;
  localparam logic [AP_CNT_W-1:0] AUTOPRE_DELAY_CYCLES = 4'h8;
  localparam logic [CA_W-1:0] CA_RESET = 10'h000;

  typedef enum logic [3:0] {
    cmd_nop, cmd_mrw, cmd_mrr, cmd_ref_bank, cmd_ref_all, cmd_activate, cmd_write,
    cmd_read, cmd_precharge, cmd_bst, cmd_enter_self_refresh_state, cmd_enter_dpd, cmd_enter_pd, cmd_exit
  } cmd_type;

  typedef enum logic [1:0] {
    pwr_active, pwr_power_down, pwr_self_refresh, pwr_deep_pd
  } power_type;
endpackage : ca_pkg
`default_nettype wire

//--- rtl/ca_link_if.sv
// Purpose: command/address link between controller and memory decoder
// Assumes: every signal is a sys_clk flop output of the controller
// Notes: ck is the divided link clock, half the sys_clk rate
`default_nettype none
interface ca_link_if;
  logic ck;
  logic cke;
  logic cs_n;
  logic [ca_pkg::CA_W-1:0] ca;
  modport ctrl (output ck, output cke, output cs_n, output ca);
  modport mem (input ck, input cke, input cs_n, input ca);
endinterface : ca_link_if
`default_nettype wire

//--- rtl/ddr_command_address_decoder.sv
// Purpose: memory-side decoder of the double-rate command/address link
// Assumes: link signals come from sys_clk flops, so no synchronisers
// Notes: link clock edges are found by comparing ck with its last value
//
// Behaviour
// - controller reinitialises after any illegal event; here the decoder only pulses illegal and the issuer never sees it
// - command type from cs, bits 0-3, cke
// - capture bus at rise and following fall
// - mode write layout: index, operand halves
// - activate carries row and bank
// - auto precharge bank after access completes
// - lowest column bit is always zero
// - precharge carries bank and all-banks flag
// - bank commands act on named bank only
// - single-bank refresh only with eight banks
// - controller drives every unused bit defined
// - self refresh, deep power-down exit asynchronous
// - only no-ops during power-down exit time
// - only no-ops during self refresh exit time
`default_nettype none
module ddr_command_address_decoder #(
  parameter int BANKS = ca_pkg::NUM_BANKS
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  ca_link_if.mem link,
  output logic cmd_valid,
  output var ca_pkg::cmd_type cmd,
  output logic [ca_pkg::BANK_W-1:0] bank,
  output logic [BANKS-1:0] bank_sel,
  output logic [ca_pkg::ROW_W-1:0] row,
  output logic [ca_pkg::COL_W-1:0] column,
  output logic [ca_pkg::MR_W-1:0] mode_reg_index,
  output logic [ca_pkg::MR_W-1:0] mode_reg_operand,
  output logic auto_precharge_flag,
  output logic all_banks_flag,
  output logic autopre_fire,
  output logic [ca_pkg::BANK_W-1:0] autopre_bank,
  output var ca_pkg::power_type power_state,
  output logic illegal
);
  import ca_pkg::*;

  logic ck_q_ff;
  logic cke_q_ff;
  logic cke_rise_ff;
  power_type pwr_ff;
  power_type nxt_pwr;
  logic pend_ff;
  cmd_type pend_cmd_ff;
  logic [CA_W-1:0] rise_ca_ff;
  logic cmd_valid_ff;
  cmd_type cmd_ff;
  logic [BANK_W-1:0] bank_ff;
  logic [BANKS-1:0] bank_sel_ff;
  logic [ROW_W-1:0] row_ff;
  logic [COL_W-1:0] col_ff;
  logic [MR_W-1:0] mr_idx_ff;
  logic [MR_W-1:0] mr_op_ff;
  logic ap_ff;
  logic ab_ff;
  logic [AP_CNT_W-1:0] ap_cnt_ff;
  logic [BANK_W-1:0] ap_bank_ff;
  logic ap_fire_ff;
  logic illegal_ff;

  // link clock edges as seen on sys_clk
  wire ck_rise = link.ck & ~ck_q_ff;
  wire ck_fall = ~link.ck & ck_q_ff;
  wire [3:0] op4 = link.ca[3:0];
  wire in_active = (pwr_ff == pwr_active);

  // command slot: cke high now and at the last rise, all sampled at rise
  wire cmd_slot = ck_rise & cke_rise_ff & link.cke & in_active;
  cmd_type rise_cmd;
  assign rise_cmd = link.cs_n ? cmd_nop :
    (op4 == OP_MRW) ? cmd_mrw :
    (op4 == OP_MRR) ? cmd_mrr :
    (op4 == OP_REF_BANK) ? cmd_ref_bank :
    (op4 == OP_REF_ALL) ? cmd_ref_all :
    (op4[1:0] == OP_ACT) ? cmd_activate :
    (op4[2:0] == OP_WRITE) ? cmd_write :
    (op4[2:0] == OP_READ) ? cmd_read :
    (op4 == OP_PRECHARGE) ? cmd_precharge :
    (op4 == OP_BST) ? cmd_bst : cmd_nop;

  // per-bank refresh is turned away on any build without eight banks
  wire ref_bad = cmd_slot & (rise_cmd == cmd_ref_bank) &
    (BANKS != PER_BANK_REFRESH_BANKS);
  wire take_rise = cmd_slot & (rise_cmd != cmd_nop) & ~ref_bad;
  wire fall_done = ck_fall & pend_ff;

  // low-power entry on a falling cke at a link rise
  wire entry_slot = ck_rise & cke_rise_ff & ~link.cke & in_active;
  cmd_type entry_cmd;
  assign entry_cmd = link.cs_n ? cmd_enter_pd :
    (op4[2:0] == OP_SELF_REFRESH_STATE) ? cmd_enter_self_refresh_state :
    (op4[2:0] == OP_DPD) ? cmd_enter_dpd : cmd_nop;
  wire entry_ok = entry_slot & (entry_cmd != cmd_nop);

  // power-down exit waits for a link rise with cs high
  wire pd_exit = ck_rise & ~cke_rise_ff & link.cke & link.cs_n &
    (pwr_ff == pwr_power_down);
  wire pd_bad = ck_rise & link.cke & ~link.cs_n & (pwr_ff == pwr_power_down);
  // link clock may be stopped here, so the cke rise is seen on sys_clk alone
  wire async_exit = link.cke & ~cke_q_ff &
    ((pwr_ff == pwr_self_refresh) | (pwr_ff == pwr_deep_pd));
  wire illegal_evt = (entry_slot & ~entry_ok) | ref_bad | pd_bad;

  assign nxt_pwr = (async_exit | pd_exit) ? pwr_active :
    ~entry_ok ? pwr_ff :
    (entry_cmd == cmd_enter_self_refresh_state) ? pwr_self_refresh :
    (entry_cmd == cmd_enter_dpd) ? pwr_deep_pd : pwr_power_down;

  // field extraction from the held rise half and the live fall half
  wire [CA_W-1:0] rh = rise_ca_ff;
  wire [CA_W-1:0] fh = link.ca;
  wire [BANK_W-1:0] f_bank = rh[RISE_BANK_POS +: BANK_W];
  wire [ROW_W-1:0] f_row = {fh[9:8], rh[RISE_ROW_POS +: 5], fh[7:0]};
  wire [COL_W-1:0] f_col = {fh[CA_W-1:FALL_COL_POS], rh[RISE_COL_POS +: 2], 1'b0};
  wire [MR_W-1:0] f_mr_idx = {fh[1:0], rh[RISE_MR_POS +: 6]};
  wire [MR_W-1:0] f_mr_op = fh[FALL_OP_POS +: MR_W];
  wire f_ap = fh[FALL_AP_POS] & ((pend_cmd_ff == cmd_read) | (pend_cmd_ff == cmd_write));
  wire f_ab = rh[RISE_AB_POS] & (pend_cmd_ff == cmd_precharge);
  wire bank_cmd = (pend_cmd_ff == cmd_activate) | (pend_cmd_ff == cmd_read) |
    (pend_cmd_ff == cmd_write) | (pend_cmd_ff == cmd_precharge);
  // a bank code beyond the build's bank count selects nothing
  wire [BANKS-1:0] one_bank = {{(BANKS-1){1'b0}}, 1'b1} << f_bank;
  wire [BANKS-1:0] f_sel = f_ab ? {BANKS{1'b1}} : bank_cmd ? one_bank : {BANKS{1'b0}};

  wire nxt_valid = fall_done | entry_ok | async_exit | pd_exit;
  cmd_type nxt_cmd;
  assign nxt_cmd = fall_done ? pend_cmd_ff : entry_ok ? entry_cmd : cmd_exit;

  // link edge history and power state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ck_q_ff <= 1'b0;
      cke_q_ff <= 1'b0;
      cke_rise_ff <= 1'b0;
      pwr_ff <= pwr_active;
    end else begin
      ck_q_ff <= link.ck;
      cke_q_ff <= link.cke;
      pwr_ff <= nxt_pwr;
      if (ck_rise) begin
        cke_rise_ff <= link.cke;
      end
    end
  end

  // hold the rising half until the falling half arrives
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_ff <= 1'b0;
      pend_cmd_ff <= cmd_nop;
      rise_ca_ff <= CA_RESET;
    end else begin
      pend_ff <= take_rise | (pend_ff & ~fall_done);
      if (take_rise) begin
        pend_cmd_ff <= rise_cmd;
        rise_ca_ff <= link.ca;
      end
    end
  end

  // command strobe and type
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid_ff <= 1'b0;
      cmd_ff <= cmd_nop;
      illegal_ff <= 1'b0;
    end else begin
      cmd_valid_ff <= nxt_valid;
      illegal_ff <= illegal_evt;
      if (nxt_valid) begin
        cmd_ff <= nxt_cmd;
      end
    end
  end

  // decoded fields, updated only when a two-half command completes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_ff <= '0;
      bank_sel_ff <= '0;
      row_ff <= '0;
      col_ff <= '0;
      mr_idx_ff <= '0;
      mr_op_ff <= '0;
      ap_ff <= 1'b0;
      ab_ff <= 1'b0;
    end else if (fall_done) begin
      bank_ff <= f_bank;
      bank_sel_ff <= f_sel;
      row_ff <= f_row;
      col_ff <= f_col;
      mr_idx_ff <= f_mr_idx;
      mr_op_ff <= f_mr_op;
      ap_ff <= f_ap;
      ab_ff <= f_ab;
    end
  end

  // auto precharge after the access; a newer one replaces a pending one
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ap_cnt_ff <= '0;
      ap_bank_ff <= '0;
      ap_fire_ff <= 1'b0;
    end else begin
      ap_fire_ff <= (ap_cnt_ff == 4'h1);
      if (fall_done & f_ap) begin
        ap_cnt_ff <= AUTOPRE_DELAY_CYCLES;
        ap_bank_ff <= f_bank;
      end else if (ap_cnt_ff != '0) begin
        ap_cnt_ff <= ap_cnt_ff - 4'h1;
      end
    end
  end

  assign cmd_valid = cmd_valid_ff;
  assign cmd = cmd_ff;
  assign bank = bank_ff;
  assign bank_sel = bank_sel_ff;
  assign row = row_ff;
  assign column = col_ff;
  assign mode_reg_index = mr_idx_ff;
  assign mode_reg_operand = mr_op_ff;
  assign auto_precharge_flag = ap_ff;
  assign all_banks_flag = ab_ff;
  assign autopre_fire = ap_fire_ff;
  assign autopre_bank = ap_bank_ff;
  assign power_state = pwr_ff;
  assign illegal = illegal_ff;
endmodule : ddr_command_address_decoder
`default_nettype wire

//--- rtl/ca_command_issuer.sv
// Purpose: controller end; turns register orders into link commands
// Assumes: Avalon-MM slave with waitrequest, byte addresses
// Notes: link clock is sys_clk divided by two and always toggles
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`default_nettype none
module ca_command_issuer (
  input wire logic sys_clk,
  input wire logic reset_n,
  ca_link_if.ctrl link,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import ca_pkg::*;

  typedef enum {st_idle, st_fall, st_exit_wait} issue_state_type;

  issue_state_type st_ff, nxt_st;
  logic [31:0] cmd_word_ff, addr_word_ff, mode_word_ff, rdata_ff;
  logic wait_ff, busy_ff, err_ff, ck_ff, cke_ff, cs_n_ff;
  logic nxt_cke, nxt_cs_n, done, fault;
  logic [CA_W-1:0] ca_ff, nxt_ca, rise_ca, fall_ca;
  logic [15:0] cnt_ff, nxt_cnt;
  power_type pwr_ff, nxt_pwr, entry_pwr;
  logic rise_cs_n, entry, known;

  // order fields
  wire cmd_type code = cmd_type'(cmd_word_ff[CMD_CODE_POS +: 4]);
  wire ap = cmd_word_ff[CMD_AP_POS];
  wire ab = cmd_word_ff[CMD_AB_POS];
  wire [BANK_W-1:0] bk = cmd_word_ff[CMD_BANK_POS +: BANK_W];
  wire [ROW_W-1:0] rw = addr_word_ff[ADDR_ROW_POS +: ROW_W];
  wire [COL_W-1:0] cl = addr_word_ff[ADDR_COL_POS +: COL_W];
  wire [MR_W-1:0] mi = mode_word_ff[MODE_IDX_POS +: MR_W];
  wire [MR_W-1:0] mo = mode_word_ff[MODE_OP_POS +: MR_W];

  // bus decode; a command write stalls while the previous one runs
  wire req = avs_read | avs_write;
  wire cmd_blocked = avs_write & (avs_address == REG_CMD) & busy_ff;
  wire wr_take = avs_write & ~wait_ff;
  wire err_clear = wr_take & (avs_address == REG_STATUS) & avs_writedata[STAT_ERR_POS];
  wire [31:0] status_word = (32'(busy_ff) << STAT_BUSY_POS) | (32'(pwr_ff) << STAT_PWR_POS) |
    (32'(err_ff) << STAT_ERR_POS);
  wire [31:0] rd_mux = (avs_address == REG_CMD) ? cmd_word_ff :
    (avs_address == REG_ADDR) ? addr_word_ff :
    (avs_address == REG_MODE) ? mode_word_ff :
    (avs_address == REG_STATUS) ? status_word : 32'h0000_0000;
  // other orders are refused outside the matching power state
  wire legal = known & ((code == cmd_exit) ? (pwr_ff != pwr_active) : (pwr_ff == pwr_active));

  // link halves per order; unused positions driven low
  always_comb begin
    rise_ca = CA_RESET;
    fall_ca = CA_RESET;
    rise_cs_n = 1'b0;
    entry = 1'b0;
    entry_pwr = pwr_active;
    known = 1'b1;
    unique case (code)
      cmd_mrw: begin
        rise_ca = {mi[5:0], OP_MRW};
        fall_ca = {mo, mi[7:6]};
      end
      cmd_mrr: begin
        rise_ca = {mi[5:0], OP_MRR};
        fall_ca = {8'h00, mi[7:6]};
      end
      cmd_ref_bank: rise_ca = {6'h00, OP_REF_BANK};
      cmd_ref_all: rise_ca = {6'h00, OP_REF_ALL};
      cmd_activate: begin
        rise_ca = {bk, rw[12:8], OP_ACT};
        fall_ca = {rw[14:13], rw[7:0]};
      end
      cmd_write, cmd_read: begin
        rise_ca = {bk, cl[2:1], 2'b00, (code == cmd_read) ? OP_READ : OP_WRITE};
        fall_ca = {cl[11:3], ap};
      end
      cmd_precharge: rise_ca = {bk, 2'b00, ab, OP_PRECHARGE};
      cmd_bst: rise_ca = {6'h00, OP_BST};
      cmd_enter_self_refresh_state: begin
        rise_ca = {7'h00, OP_SELF_REFRESH_STATE};
        entry = 1'b1;
        entry_pwr = pwr_self_refresh;
      end
      cmd_enter_dpd: begin
        rise_ca = {7'h00, OP_DPD};
        entry = 1'b1;
        entry_pwr = pwr_deep_pd;
      end
      cmd_enter_pd: begin
        rise_cs_n = 1'b1;
        entry = 1'b1;
        entry_pwr = pwr_power_down;
      end
      cmd_nop, cmd_exit: rise_cs_n = 1'b1;
      default: begin
        rise_cs_n = 1'b1;
        known = 1'b0;
      end
    endcase
  end

  // issue sequencing; a rise half goes out only when ck is about to rise
  always_comb begin
    nxt_st = st_ff;
    nxt_cs_n = 1'b1;
    nxt_ca = CA_RESET;
    nxt_cke = cke_ff;
    nxt_cnt = cnt_ff;
    nxt_pwr = pwr_ff;
    done = 1'b0;
    fault = 1'b0;
    unique case (st_ff)
      st_idle: begin
        if (busy_ff & ~ck_ff & ~legal) begin
          fault = 1'b1;
          done = 1'b1;
        end else if (busy_ff & ~ck_ff & (code == cmd_exit)) begin
          nxt_cke = 1'b1;
          nxt_pwr = pwr_active;
          nxt_cnt = (pwr_ff == pwr_power_down) ? POWERDOWN_EXIT_CYCLES
            : SELFREFRESH_EXIT_CYCLES;
          nxt_st = st_exit_wait;
        end else if (busy_ff & ~ck_ff) begin
          nxt_cs_n = rise_cs_n;
          nxt_ca = rise_ca;
          nxt_cke = ~entry;
          nxt_pwr = entry ? entry_pwr : pwr_ff;
          nxt_st = st_fall;
        end
      end
      st_fall: begin
        nxt_ca = fall_ca;
        done = 1'b1;
        nxt_st = st_idle;
      end
      st_exit_wait: begin
        // only no-ops go out while ck keeps toggling
        nxt_cnt = cnt_ff - 16'h0001;
        if (cnt_ff <= 16'h0001) begin
          done = 1'b1;
          nxt_st = st_idle;
        end
      end
    endcase
  end

  // link drivers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= st_idle;
      ck_ff <= 1'b0;
      cke_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      ca_ff <= CA_RESET;
      cnt_ff <= '0;
      pwr_ff <= pwr_active;
    end else begin
      st_ff <= nxt_st;
      ck_ff <= ~ck_ff;
      cke_ff <= nxt_cke;
      cs_n_ff <= nxt_cs_n;
      ca_ff <= nxt_ca;
      cnt_ff <= nxt_cnt;
      pwr_ff <= nxt_pwr;
    end
  end

  // bus slave: one wait-free cycle per accepted request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= ~(wait_ff & req & ~cmd_blocked);
      if (wait_ff & req & ~cmd_blocked) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // order registers; a fault wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_word_ff <= 32'h0000_0000;
      addr_word_ff <= 32'h0000_0000;
      mode_word_ff <= 32'h0000_0000;
      busy_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      err_ff <= fault | (err_ff & ~err_clear);
      busy_ff <= (wr_take & (avs_address == REG_CMD)) | (busy_ff & ~done);
      if (wr_take & (avs_address == REG_CMD)) begin
        cmd_word_ff <= avs_writedata;
      end
      if (wr_take & (avs_address == REG_ADDR)) begin
        addr_word_ff <= avs_writedata;
      end
      if (wr_take & (avs_address == REG_MODE)) begin
        mode_word_ff <= avs_writedata;
      end
    end
  end

  assign link.ck = ck_ff;
  assign link.cke = cke_ff;
  assign link.cs_n = cs_n_ff;
  assign link.ca = ca_ff;
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
endmodule : ca_command_issuer
`default_nettype wire

//--- verif/ca_link_assertions.sv
// Purpose: link and decode checks between issuer and decoder
// Assumes: one sys_clk domain, link driven from sys_clk flops
// Notes: a link rise is ck high where it was low one edge before
`default_nettype none
module ca_link_assertions #(
  parameter int BANKS = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [ca_pkg::CA_W-1:0] ca,
  input wire logic cmd_valid,
  input wire ca_pkg::cmd_type cmd,
  input wire logic [ca_pkg::BANK_W-1:0] bank,
  input wire logic [BANKS-1:0] bank_sel,
  input wire logic [ca_pkg::COL_W-1:0] column,
  input wire logic auto_precharge_flag,
  input wire logic autopre_fire,
  input wire ca_pkg::power_type power_state
);
  import ca_pkg::*;
  logic ck_q;
  logic cmd_rise;
  // ck history, reset low like the divider so no false rise
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ck_q <= 1'b0;
    end else begin
      ck_q <= ck;
    end
  end
  // selected rise half while active
  assign cmd_rise = ck && !ck_q && !cs_n && cke && power_state == pwr_active;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  chk_ck_divide: assert property ($past(reset_n) |-> ck != $past(ck))
    else $error("link clock stopped toggling");
  chk_mrw_decode: assert property (cmd_rise && $past(cke) && ca[3:0] == 4'h0
    |-> ##[2:3] cmd_valid && cmd == cmd_mrw) else $error("mode write missed");
  chk_act_decode: assert property (cmd_rise && ca[1:0] == 2'h2
    |-> ##[2:3] cmd_valid && cmd == cmd_activate) else $error("activate missed");
  chk_read_decode: assert property (cmd_rise && ca[2:0] == 3'h5
    |-> ##[2:3] cmd_valid && cmd == cmd_read) else $error("read missed");
  chk_ref_bank: assert property (cmd_rise && ca[3:0] == 4'h4
    |-> ##[2:3] cmd_valid && cmd == cmd_ref_bank) else $error("bank refresh missed");
  chk_col_lsb: assert property (cmd_valid |-> column[0] == 1'b0)
    else $error("column low bit set");
  chk_bank_onehot: assert property (cmd_valid && cmd == cmd_activate
    |-> bank_sel == (BANKS'(1) << bank)) else $error("wrong bank selected");
  chk_autopre_time: assert property (cmd_valid && auto_precharge_flag
    && (cmd == cmd_read || cmd == cmd_write) |-> ##[8:10] autopre_fire)
    else $error("auto precharge late");
  chk_pd_entry: assert property (ck && !ck_q && cs_n && !cke && $past(cke)
    && power_state == pwr_active |-> ##[1:2] power_state == pwr_power_down)
    else $error("power-down not entered");
  chk_exit_quiet: assert property ($rose(cke) && power_state == pwr_power_down
    |-> (cs_n || ca[2:0] == 3'h7) [*5]) else $error("command during exit time");
  chk_self_refresh_state_quiet: assert property ($rose(cke) && (power_state == pwr_self_refresh
    || power_state == pwr_deep_pd) |-> cs_n [*8]) else $error("command during self_refresh_state exit");
endmodule : ca_link_assertions
`default_nettype wire

//--- verif/ddr_command_address_decoder_bench.sv
// Purpose: issuer and decoder joined by the link, driven over Avalon-MM
// Assumes: each request held until waitrequest is sampled low
// Notes: expectations come from the link encodings, not the design
`default_nettype none
module ddr_command_address_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ca_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, cmd_valid, ap_flag, ab_flag, autopre_fire, illegal;
  cmd_type cmd;
  power_type power_state;
  logic [BANK_W-1:0] bank, autopre_bank;
  logic [NUM_BANKS-1:0] bank_sel;
  logic [ROW_W-1:0] row;
  logic [COL_W-1:0] column;
  logic [MR_W-1:0] mr_idx, mr_op;
  logic [CA_W-1:0] rise_ca, fall_ca;
  logic ck_q = 1'b0;
  logic grab = 1'b0;
  int n_errors = 0;
  int samples_checked = 0;
  int n_cmd = 0;
  int n_ap = 0;
  int n_ill = 0;
  int codes[3] = '{3, 4, 9};
  cmd_type exps[3] = '{cmd_ref_bank, cmd_ref_all, cmd_bst};
  logic [3:0] rcode[3] = '{4'h4, 4'hc, 4'h3};
  int ent[3] = '{12, 10, 11};
  cmd_type eexp[3] = '{cmd_enter_pd, cmd_enter_self_refresh_state, cmd_enter_dpd};
  power_type pexp[3] = '{pwr_power_down, pwr_self_refresh, pwr_deep_pd};

  ca_link_if link ();
  ca_command_issuer i_ca_command_issuer (.sys_clk, .reset_n, .link(link), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  ddr_command_address_decoder #(.BANKS(NUM_BANKS)) i_ddr_command_address_decoder (
    .sys_clk, .reset_n, .link(link), .cmd_valid, .cmd, .bank, .bank_sel, .row, .column,
    .mode_reg_index(mr_idx), .mode_reg_operand(mr_op), .auto_precharge_flag(ap_flag),
    .all_banks_flag(ab_flag), .autopre_fire, .autopre_bank, .power_state, .illegal);
  ca_link_assertions #(.BANKS(NUM_BANKS)) i_ca_link_assertions (.sys_clk, .reset_n,
    .ck(link.ck), .cke(link.cke), .cs_n(link.cs_n), .ca(link.ca), .cmd_valid, .cmd,
    .bank, .bank_sel, .column, .auto_precharge_flag(ap_flag), .autopre_fire, .power_state);

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // pulse counters and both halves of each selected command
  always @(posedge sys_clk) begin
    ck_q <= link.ck;
    grab <= 1'b0;
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (autopre_fire === 1'b1) n_ap <= n_ap + 1;
    if (illegal === 1'b1) n_ill <= n_ill + 1;
    if (grab) fall_ca <= link.ca;
    if (link.ck === 1'b1 && ck_q === 1'b0 && link.cs_n === 1'b0) begin
      rise_ca <= link.ca;
      grab <= 1'b1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // one Avalon access; a busy issuer may stall a command write
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 400) begin
      n_errors++;
      conclude();
    end
    @(posedge sys_clk);
  endtask : bus
  function automatic logic [31:0] cw(input int c, input logic ap, input logic ab, int bk);
    return 32'(c) | (32'(ap) << 4) | (32'(ab) << 5) | (32'(bk) << 8);
  endfunction : cw
  task automatic do_cmd(input logic [31:0] w, input cmd_type exp);
    int base;
    int i;
    base = n_cmd;
    bus(1'b1, REG_CMD, w);
    for (i = 0; i < 400 && n_cmd == base; i++) @(posedge sys_clk);
    if (n_cmd == base) begin
      n_errors++;
      conclude();
    end
    check("cmd", 32'(cmd), 32'(exp));
  endtask : do_cmd

  initial begin
    int apb;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    check("idle wait", 32'(avs_waitrequest), 32'h0000_0001);
    // mode write and read: index and operand across both halves
    bus(1'b1, REG_MODE, 32'h0000_3ca5);
    do_cmd(cw(1, 0, 0, 0), cmd_mrw);
    check("mr op", 32'(mr_op), 32'h0000_003c);
    check("mrw rise", 32'(rise_ca), 32'h0000_0250);
    check("mrw fall", 32'(fall_ca), 32'h0000_00f2);
    bus(1'b1, REG_MODE, 32'h0000_00c7);
    do_cmd(cw(2, 0, 0, 0), cmd_mrr);
    check("mrr rise", 32'(rise_ca), 32'h0000_0078);
    check("mr idx", 32'(mr_idx), 32'h0000_00c7);
    $display("mode register test done");
    // activate, then write with auto precharge and odd column
    bus(1'b1, REG_ADDR, 32'h09a7_6d5b);
    do_cmd(cw(5, 0, 0, 5), cmd_activate);
    check("row", 32'(row), 32'h0000_6d5b);
    check("act sel", 32'(bank_sel), 32'h0000_0020);
    check("act rise", 32'(rise_ca), 32'h0000_02b6);
    check("act fall", 32'(fall_ca), 32'h0000_035b);
    apb = n_ap;
    do_cmd(cw(6, 1, 0, 3), cmd_write);
    check("column", 32'(column), 32'h0000_09a6);
    check("ap flag", 32'(ap_flag), 32'h0000_0001);
    check("wr fall", 32'(fall_ca), 32'h0000_0269);
    repeat (20) @(posedge sys_clk);
    check("ap count", 32'(n_ap - apb), 32'h0000_0001);
    check("ap bank", 32'(autopre_bank), 32'h0000_0003);
    do_cmd(cw(7, 0, 0, 2), cmd_read);
    check("rd sel", 32'(bank_sel), 32'h0000_0004);
    check("rd bank", 32'(bank), 32'h0000_0002);
    do_cmd(cw(8, 0, 1, 1), cmd_precharge);
    check("pre sel", 32'(bank_sel), 32'h0000_00ff);
    check("ab flag", 32'(ab_flag), 32'h0000_0001);
    check("pre rise", 32'(rise_ca), 32'h0000_009b);
    check("pre fall", 32'(fall_ca), 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      do_cmd(cw(codes[k], 0, 0, 0), exps[k]);
      check("code", 32'(rise_ca[3:0]), 32'(rcode[k]));
    end
    $display("bank command test done");
    // refused code sets err; unmapped read gives zero
    bus(1'b1, REG_CMD, cw(14, 0, 0, 0));
    // the fault lands one or two edges later, depending on the ck phase
    repeat (4) @(posedge sys_clk);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    check("err", 32'(rd[3]), 32'h0000_0001);
    bus(1'b1, REG_STATUS, 32'h0000_0008);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    check("err clr", 32'(rd[3]), 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000);
    check("unmapped", rd, 32'h0000_0000);
    // each power state entered and left
    for (int k = 0; k < 3; k++) begin
      do_cmd(cw(ent[k], 0, 0, 0), eexp[k]);
      check("pwr", 32'(power_state), 32'(pexp[k]));
      check("cke", 32'(link.cke), 32'h0000_0000);
      do_cmd(cw(13, 0, 0, 0), cmd_exit);
      check("pwr exit", 32'(power_state), 32'(pwr_active));
    end
    check("illegal", 32'(n_ill), 32'h0000_0000);
    $display("power state test done");
    conclude();
  end
endmodule : ddr_command_address_decoder_bench
`default_nettype wire
